// *** verilog/scr_device.sv ***
// Register core of the serial configuration port: setup, identity, index and function bytes.
// Assumes the link strobes are one cycle long, synchronous to core_clk, never both at once.
//
// How it works
// R01 - Every location is one byte wide.
// R02 - Setup, index/transfer and function address groups.
// R03 - Bit 7 is the most significant bit.
// R04 - Function bytes become active only after commit.
// R05 - Host writes no undefined addresses.
// R06 - Host writes zero into reserved bits.
// R07 - Any reset loads documented defaults automatically.
// R08 - Port setup mirrors order bit; fixed bits; 0x18.
// R09 - Host mirrors fields; device honours either copy.
// R10 - Soft-reset field resets chip when set.
// R11 - Part identifier is read-only and fixed.
// R12 - Speed grade code sits in bits 5:4.
// R13 - Commit bit copies master to active at once.
// R14 - MSB first after reset; changed by setup only.
// R15 - Soft-reset field clears itself after reset.
// R16 - Writes to read-only bytes are ignored.
`include "scr_consts.svh"
module scr_device #(
  // Arbitrary value, not the identity of any real part.
  parameter logic [7:0] PART_ID = `SCR_PART_ID,
  parameter logic [1:0] SPEED_CODE = `SCR_SPEED_CODE
) (
  input wire logic core_clk,
  input wire logic reset_n,
  scr_link_if.dev link,
  input wire logic [5:0] act_sel,
  output logic [7:0] act_data_q,
  output logic lsb_first,
  output logic soft_reset_busy,
  output logic [7:0] index2_q,
  output logic [7:0] index1_q
);
  // ------------------------------------------------------------
  // Setup and index bytes
  // ------------------------------------------------------------
  logic [7:0] port_q;
  logic [7:0] port_d;
  logic [7:0] index2_d;
  logic [7:0] index1_d;
  logic srst_q;
  logic srst_d;
  logic commit;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] act_data_d;
  logic [7:0] func_master [`SCR_FUNC_NUM];
  logic [7:0] func_active [`SCR_FUNC_NUM];
  logic [7:0] grade_byte;
  logic [5:0] rd_idx;
  logic new_lsb;
  logic new_srst;

  // Either mirror copy counts, so a write in the wrong bit order still lands.
  assign new_lsb = link.wdata[`SCR_B_LSB_HI] | link.wdata[`SCR_B_LSB_LO]; // see R09
  assign new_srst = link.wdata[`SCR_B_SRST_HI] | link.wdata[`SCR_B_SRST_LO]; // see R09

  always_comb begin
    grade_byte = `SCR_BYTE_ZERO;
    grade_byte[`SCR_B_GRADE_HI:`SCR_B_GRADE_LO] = SPEED_CODE; // see R12
  end

  assign commit = link.wr && !srst_q && (link.addr == `SCR_A_COMMIT) &&
    link.wdata[`SCR_B_COMMIT]; // see R13

  always_comb begin
    port_d = port_q;
    index2_d = index2_q;
    index1_d = index1_q;
    srst_d = 1'b0;
    if (srst_q) begin
      // Internal reset cycle: defaults return and the soft-reset bits drop.
      port_d = `SCR_PORT_RST; // see R10
      index2_d = `SCR_IDX_RST;
      index1_d = `SCR_IDX_RST;
    end else if (link.wr) begin
      case (link.addr)
        `SCR_A_PORT: begin
          port_d = `SCR_PORT_FIXED; // see R08
          port_d[`SCR_B_LSB_HI] = new_lsb; // see R14
          port_d[`SCR_B_LSB_LO] = new_lsb;
          port_d[`SCR_B_SRST_HI] = new_srst;
          port_d[`SCR_B_SRST_LO] = new_srst;
          srst_d = new_srst; // see R10
        end
        `SCR_A_IDX2: begin
          index2_d = link.wdata & scr_pkg::scr_wmask(link.addr);
        end
        `SCR_A_IDX1: begin
          index1_d = link.wdata & scr_pkg::scr_wmask(link.addr);
        end
        // Identifier and grade bytes have no storage, so writes fall through.
        default: begin
          port_d = port_q; // see R16
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_q <= `SCR_PORT_RST; // see R03 R07
      index2_q <= `SCR_IDX_RST;
      index1_q <= `SCR_IDX_RST;
      srst_q <= 1'b0;
    end else begin
      port_q <= port_d;
      index2_q <= index2_d;
      index1_q <= index1_d;
      srst_q <= srst_d; // see R15
    end
  end

  // ------------------------------------------------------------
  // Double-buffered function bytes
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `SCR_FUNC_NUM; gi++) begin : g_func
      scr_buf_cell #(
        .RST_VAL(`SCR_FUNC_RST)
      ) u_cell (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clear(srst_q),
        .wr_en(link.wr && !srst_q &&
          (link.addr == 8'(`SCR_A_FUNC_LO + gi))), // see R04
        .wdata(link.wdata),
        .commit(commit),
        .master_q(func_master[gi]),
        .active_q(func_active[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  assign rd_idx = 6'(link.addr - `SCR_A_FUNC_LO);

  always_comb begin
    rdata_d = rdata_q;
    if (link.rd) begin
      case (link.addr)
        `SCR_A_PORT: rdata_d = port_q;
        `SCR_A_ID: rdata_d = PART_ID; // see R11
        `SCR_A_GRADE: rdata_d = grade_byte; // see R12
        `SCR_A_IDX2: rdata_d = index2_q;
        `SCR_A_IDX1: rdata_d = index1_q;
        // The commit bit is a one-shot, so it always reads back as zero.
        `SCR_A_COMMIT: rdata_d = `SCR_BYTE_ZERO;
        default: begin
          rdata_d = scr_pkg::scr_is_func(link.addr) ? func_master[rd_idx] :
            `SCR_BYTE_ZERO; // see R02
        end
      endcase
    end
  end

  always_comb begin
    act_data_d = `SCR_BYTE_ZERO;
    if (act_sel < 6'(`SCR_FUNC_NUM)) begin
      act_data_d = func_active[act_sel];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= `SCR_BYTE_ZERO;
      act_data_q <= `SCR_FUNC_RST;
    end else begin
      rdata_q <= rdata_d; // see R01
      act_data_q <= act_data_d;
    end
  end

  assign link.rdata = rdata_q;
  assign lsb_first = port_q[`SCR_B_LSB_HI];
  assign soft_reset_busy = srst_q;
endmodule

// *** verilog/scr_consts.svh ***
// Constants of the configuration register core and its host controller.
// Assumes it is included by the package and the modules by its bare name.
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH
`define SCR_A_PORT 8'h00
`define SCR_A_ID 8'h01
`define SCR_A_GRADE 8'h02
`define SCR_A_IDX2 8'h04
`define SCR_A_IDX1 8'h05
`define SCR_A_COMMIT 8'hFF
`define SCR_A_FUNC_LO 8'h08
`define SCR_A_FUNC_HI 8'h2D
`define SCR_FUNC_NUM 38
`define SCR_PORT_RST 8'h18
`define SCR_PORT_FIXED 8'h18
`define SCR_PORT_WMASK 8'h66
`define SCR_IDX_RST 8'h0F
`define SCR_IDX2_WMASK 8'h0F
`define SCR_IDX1_WMASK 8'h3F
`define SCR_COMMIT_WMASK 8'h01
`define SCR_FUNC_RST 8'h00
`define SCR_BYTE_ZERO 8'h00
`define SCR_BYTE_ONES 8'hFF
`define SCR_B_LSB_HI 6
`define SCR_B_LSB_LO 1
`define SCR_B_SRST_HI 5
`define SCR_B_SRST_LO 2
`define SCR_B_COMMIT 0
`define SCR_B_GRADE_LO 4
`define SCR_B_GRADE_HI 5
`define SCR_PART_ID 8'h5A
`define SCR_SPEED_CODE 2'h0
`define SCR_H_TADDR 4'h0
`define SCR_H_WDATA 4'h1
`define SCR_H_CMD 4'h2
`define SCR_H_STATUS 4'h3
`define SCR_H_RDATA 4'h4
`define SCR_C_WRITE 0
`define SCR_C_READ 1
`define SCR_C_SETUP 2
`define SCR_C_COMMIT 3
`define SCR_S_BUSY 0
`define SCR_S_REFUSED 1
`endif

// *** verilog/scr_pkg.sv ***
// Types and shared address decoding of the configuration register core.
// Assumes scr_consts.svh is on the include path.
`include "scr_consts.svh"
package scr_pkg;
  typedef logic [7:0] scr_byte_t;
  typedef enum logic [0:0] {SCR_IDLE, SCR_BUSY} scr_host_state_t;

  function automatic logic scr_is_func(input scr_byte_t a);
    return (a >= `SCR_A_FUNC_LO) && (a <= `SCR_A_FUNC_HI);
  endfunction

  function automatic logic scr_is_defined(input scr_byte_t a);
    return scr_is_func(a) || (a == `SCR_A_PORT) || (a == `SCR_A_ID) ||
      (a == `SCR_A_GRADE) || (a == `SCR_A_IDX2) || (a == `SCR_A_IDX1) ||
      (a == `SCR_A_COMMIT);
  endfunction

  function automatic scr_byte_t scr_wmask(input scr_byte_t a);
    scr_byte_t m;
    m = `SCR_BYTE_ZERO;
    case (a)
      `SCR_A_PORT: m = `SCR_PORT_WMASK;
      `SCR_A_IDX2: m = `SCR_IDX2_WMASK;
      `SCR_A_IDX1: m = `SCR_IDX1_WMASK;
      `SCR_A_COMMIT: m = `SCR_COMMIT_WMASK;
      default: m = scr_is_func(a) ? `SCR_BYTE_ONES : `SCR_BYTE_ZERO;
    endcase
    return m;
  endfunction
endpackage

// *** verilog/scr_link_if.sv ***
// Byte-wide register link between the host controller and the register core.
// Assumes both ends run on the same core clock.
interface scr_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// *** verilog/scr_buf_cell.sv ***
// One double-buffered byte: a master copy written by the host and an active copy.
// Assumes commit and clear are one-cycle pulses from the register core.
`include "scr_consts.svh"
module scr_buf_cell #(
  parameter logic [7:0] RST_VAL = `SCR_FUNC_RST
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  input wire logic commit,
  output logic [7:0] master_q,
  output logic [7:0] active_q
);
  logic [7:0] master_d;
  logic [7:0] active_d;

  always_comb begin
    master_d = master_q;
    active_d = active_q;
    if (clear) begin
      master_d = RST_VAL;
      active_d = RST_VAL;
    end else begin
      if (wr_en) begin
        master_d = wdata;
      end
      // The copy takes the master as it stood before this edge.
      if (commit) begin
        active_d = master_q; // see R13
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      master_q <= RST_VAL;
      active_q <= RST_VAL;
    end else begin
      master_q <= master_d;
      active_q <= active_d;
    end
  end
endmodule

// *** verilog/scr_host.sv ***
// Host controller that programs the register core over the byte link.
// Assumes software drives the plain command port, one strobe per cycle.
`include "scr_consts.svh"
module scr_host (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [3:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  scr_link_if.host link
);
  // ------------------------------------------------------------
  // Command registers and link sequencer
  // ------------------------------------------------------------
  scr_pkg::scr_host_state_t state_q;
  scr_pkg::scr_host_state_t state_d;
  logic [7:0] taddr_q, taddr_d;
  logic [7:0] wbuf_q, wbuf_d;
  logic [7:0] rbuf_q, rbuf_d;
  logic refused_q, refused_d;
  logic [7:0] lk_addr_q, lk_addr_d;
  logic [7:0] lk_wdata_q, lk_wdata_d;
  logic lk_wr_q, lk_wr_d;
  logic lk_rd_q, lk_rd_d;
  logic rd_pend_q, rd_pend_d;
  logic [7:0] sw_rdata_q, sw_rdata_d;
  logic cmd;
  logic [7:0] setup;

  assign cmd = sw_wr && (sw_addr == `SCR_H_CMD) && (state_q == scr_pkg::SCR_IDLE);

  // Both mirror copies are written alike and every other setup bit is fixed.
  always_comb begin
    setup = `SCR_PORT_FIXED;
    setup[`SCR_B_LSB_HI] = wbuf_q[0]; // see R09
    setup[`SCR_B_LSB_LO] = wbuf_q[0];
    setup[`SCR_B_SRST_HI] = wbuf_q[1];
    setup[`SCR_B_SRST_LO] = wbuf_q[1];
  end

  always_comb begin
    state_d = state_q;
    taddr_d = taddr_q;
    wbuf_d = wbuf_q;
    rbuf_d = rbuf_q;
    refused_d = refused_q;
    lk_addr_d = lk_addr_q;
    lk_wdata_d = lk_wdata_q;
    lk_wr_d = 1'b0;
    lk_rd_d = 1'b0;
    sw_rdata_d = `SCR_BYTE_ZERO;
    // The core registers its read byte at the strobe's edge, so it is taken one cycle later.
    rd_pend_d = lk_rd_q;
    if (rd_pend_q) begin
      rbuf_d = link.rdata;
    end
    if (sw_wr && sw_addr == `SCR_H_TADDR) begin
      taddr_d = sw_wdata;
    end
    if (sw_wr && sw_addr == `SCR_H_WDATA) begin
      wbuf_d = sw_wdata;
    end
    if (sw_wr && sw_addr == `SCR_H_STATUS && sw_wdata[`SCR_S_REFUSED]) begin
      refused_d = 1'b0;
    end
    case (state_q)
      scr_pkg::SCR_IDLE: begin
        if (cmd && sw_wdata[`SCR_C_COMMIT]) begin
          lk_addr_d = `SCR_A_COMMIT; // see R04 R13
          lk_wdata_d = `SCR_COMMIT_WMASK;
          lk_wr_d = 1'b1;
          state_d = scr_pkg::SCR_BUSY;
        end else if (cmd && sw_wdata[`SCR_C_SETUP]) begin
          lk_addr_d = `SCR_A_PORT;
          lk_wdata_d = setup;
          lk_wr_d = 1'b1;
          state_d = scr_pkg::SCR_BUSY;
        end else if (cmd && sw_wdata[`SCR_C_WRITE]) begin
          // Undefined and read-only targets are never written.
          if (scr_pkg::scr_wmask(taddr_q) == `SCR_BYTE_ZERO) begin
            refused_d = 1'b1; // see R05
          end else begin
            lk_addr_d = taddr_q;
            lk_wdata_d = wbuf_q & scr_pkg::scr_wmask(taddr_q); // see R06
            lk_wr_d = 1'b1;
            state_d = scr_pkg::SCR_BUSY;
          end
        end else if (cmd && sw_wdata[`SCR_C_READ]) begin
          lk_addr_d = taddr_q;
          lk_rd_d = 1'b1;
          state_d = scr_pkg::SCR_BUSY;
        end
      end
      scr_pkg::SCR_BUSY: begin
        state_d = scr_pkg::SCR_IDLE;
      end
      default: begin
        state_d = scr_pkg::SCR_IDLE;
      end
    endcase
    if (sw_rd) begin
      case (sw_addr)
        `SCR_H_TADDR: sw_rdata_d = taddr_q;
        `SCR_H_WDATA: sw_rdata_d = wbuf_q;
        `SCR_H_STATUS: begin
          sw_rdata_d[`SCR_S_BUSY] = (state_q != scr_pkg::SCR_IDLE);
          sw_rdata_d[`SCR_S_REFUSED] = refused_q;
        end
        `SCR_H_RDATA: sw_rdata_d = rbuf_q;
        default: sw_rdata_d = `SCR_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= scr_pkg::SCR_IDLE;
      taddr_q <= `SCR_BYTE_ZERO;
      wbuf_q <= `SCR_BYTE_ZERO;
      rbuf_q <= `SCR_BYTE_ZERO;
      refused_q <= 1'b0;
      lk_addr_q <= `SCR_BYTE_ZERO;
      lk_wdata_q <= `SCR_BYTE_ZERO;
      lk_wr_q <= 1'b0;
      lk_rd_q <= 1'b0;
      rd_pend_q <= 1'b0;
      sw_rdata_q <= `SCR_BYTE_ZERO;
    end else begin
      state_q <= state_d;
      taddr_q <= taddr_d;
      wbuf_q <= wbuf_d;
      rbuf_q <= rbuf_d;
      refused_q <= refused_d;
      lk_addr_q <= lk_addr_d;
      lk_wdata_q <= lk_wdata_d;
      lk_wr_q <= lk_wr_d;
      lk_rd_q <= lk_rd_d;
      rd_pend_q <= rd_pend_d;
      sw_rdata_q <= sw_rdata_d;
    end
  end

  assign link.addr = lk_addr_q;
  assign link.wdata = lk_wdata_q;
  assign link.wr = lk_wr_q;
  assign link.rd = lk_rd_q;
  assign sw_rdata = sw_rdata_q;
endmodule

// *** tb/scr_link_checker.sv ***
// Concurrent checks on the byte link between host controller and register core.
// Assumes one core clock; the link signals come in as plain inputs.
`include "scr_consts.svh"
module scr_link_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Link properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_one_strobe;
    !(wr && rd);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("wr and rd together");
  property p_wr_pulse;
    wr |=> !wr;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("wr longer than a cycle");
  property p_rd_pulse;
    rd |=> !rd;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("rd longer than a cycle");
  property p_port_fixed;
    rd && addr == 8'h00 |=> rdata[4:3] == 2'b11 && !rdata[7] && !rdata[0];
  endproperty
  a_port_fixed: assert property (p_port_fixed) else $error("port fixed bits wrong");
  property p_ident;
    rd && addr == 8'h01 |=> rdata == `SCR_PART_ID;
  endproperty
  a_ident: assert property (p_ident) else $error("identifier read wrong");
  property p_grade;
    rd && addr == 8'h02 |=> rdata == {2'b00, `SCR_SPEED_CODE, 4'h0};
  endproperty
  a_grade: assert property (p_grade) else $error("speed grade read wrong");
  property p_undef_zero;
    rd && (addr == 8'h03 || addr > 8'h2D) |=> rdata == 8'h00;
  endproperty
  a_undef_zero: assert property (p_undef_zero) else $error("undefined read nonzero");
  property p_index_mask;
    rd && addr[7:1] == 7'h02 |=> (rdata & ($past(addr[0]) ? 8'hC0 : 8'hF0)) == 8'h00;
  endproperty
  a_index_mask: assert property (p_index_mask) else $error("index spare bits set");
  property p_wr_legal;
    wr |-> (addr == 8'h00 || addr == 8'h04 || addr == 8'h05 || addr == 8'hFF ||
      (addr >= 8'h08 && addr <= 8'h2D)) && (addr != 8'hFF || wdata[7:1] == 7'h00);
  endproperty
  a_wr_legal: assert property (p_wr_legal) else $error("write to a refused place");
endmodule

// *** tb/tb.sv ***
// Self-checking bench: host controller and register core joined by the byte link.
// Assumes the design files are compiled first; only reset_n, the software port and act_sel are driven.
`include "scr_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [5:0] act_sel = 6'h00;
  logic [7:0] sw_rdata, act_data_q, index2_q, index1_q, got;
  logic lsb_first, soft_reset_busy;
  int n_fail = 0;
  int n_checks = 0;
  int pulses;
  scr_link_if scr_link_if_inst ();
  scr_device scr_device_inst (.core_clk(core_clk), .reset_n(reset_n), .link(scr_link_if_inst),
    .act_sel(act_sel), .act_data_q(act_data_q), .lsb_first(lsb_first),
    .soft_reset_busy(soft_reset_busy), .index2_q(index2_q), .index1_q(index1_q));
  scr_host scr_host_inst (.core_clk(core_clk), .reset_n(reset_n), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .link(scr_link_if_inst));
  scr_link_checker scr_link_checker_inst (.core_clk(core_clk), .reset_n(reset_n),
    .addr(scr_link_if_inst.addr), .wdata(scr_link_if_inst.wdata), .wr(scr_link_if_inst.wr),
    .rd(scr_link_if_inst.rd), .rdata(scr_link_if_inst.rdata));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic sw_w(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_r(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    @(negedge core_clk);
    d = sw_rdata;
  endtask
  // The gap keeps every command clear of the controller's busy cycle.
  task automatic cmd(input logic [7:0] c);
    sw_w(4'h2, c);
    repeat (2) @(posedge core_clk);
  endtask
  task automatic dev_w(input logic [7:0] a, input logic [7:0] d);
    sw_w(4'h0, a);
    sw_w(4'h1, d);
    cmd(8'h01);
    @(negedge core_clk);
  endtask
  task automatic dev_rd(input logic [7:0] a, input logic [7:0] e);
    sw_w(4'h0, a);
    cmd(8'h02);
    sw_r(4'h4, got);
    chk(got, e);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (4000) @(posedge core_clk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    chk(index2_q, 8'h0F);
    chk(index1_q, 8'h0F);
    chk({7'h00, lsb_first}, 8'h00);
    dev_rd(8'h00, 8'h18);
    dev_rd(8'h01, `SCR_PART_ID);
    dev_rd(8'h02, 8'h00);
    dev_rd(8'h03, 8'h00);
    dev_rd(8'hFF, 8'h00);
    dev_w(8'h01, 8'h33);
    sw_r(4'h3, got);
    chk(got, 8'h02);
    sw_w(4'h3, 8'h02);
    sw_r(4'h3, got);
    chk(got, 8'h00);
    dev_rd(8'h01, `SCR_PART_ID);
    dev_w(8'h04, 8'hFF);
    dev_w(8'h05, 8'hFF);
    chk(index2_q, 8'h0F);
    chk(index1_q, 8'h3F);
    dev_w(8'h04, 8'h00);
    chk(index2_q, 8'h00);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      act_sel <= i ? 6'h25 : 6'h00;
      dev_w(i ? 8'h2D : 8'h08, i ? 8'hA5 : 8'h5A);
      chk(act_data_q, 8'h00);
      dev_rd(i ? 8'h2D : 8'h08, i ? 8'hA5 : 8'h5A);
      cmd(8'h08);
      @(negedge core_clk);
      chk(act_data_q, i ? 8'hA5 : 8'h5A);
    end
    for (int i = 1; i >= 0; i--) begin
      sw_w(4'h1, i[7:0]);
      cmd(8'h04);
      dev_rd(8'h00, i ? 8'h5A : 8'h18);
      chk({7'h00, lsb_first}, i[7:0]);
    end
    sw_w(4'h1, 8'h02);
    sw_w(4'h2, 8'h04);
    pulses = 0;
    repeat (8) begin
      @(negedge core_clk);
      if (soft_reset_busy === 1'b1) pulses++;
    end
    chk(pulses[7:0], 8'h01);
    chk(index2_q, 8'h0F);
    chk(act_data_q, 8'h00);
    dev_rd(8'h00, 8'h18);
    dev_rd(8'h2D, 8'h00);
    tally_and_finish();
  end
endmodule
